// file: core/coid_pkg.sv
// Contract
// - only instruction and data registers, chosen by the register select line alone
// - while busy, only busy and address read is accepted; others ignored
// - busy reads 1 during execution, 0 once next instruction can be taken
// - clear blanks display ram, counter to zero, within clear time
// - home zeroes counter, undoes display shift, keeps display ram
// - entry mode loads step direction and entry shift enable
// - display control loads display on, cursor visible, blink enable
// - shift instruction with low bits 00 moves cursor or shifts display
// - shift instruction with low bits 11 loads graphics mode and supply on
// - function set loads bus width, line count, font height, font table
// - glyph address instruction loads address, targets glyph ram
// - display address instruction loads address, targets display ram
// - status read returns busy on bit 7, counter on bits 6..0
// - data write stores byte into last addressed ram
// - data read returns byte at currently addressed ram location
// - each ram data write steps the address by one
// - entry shift happens together with the display ram data write
// - counter steps after ram access, visible when busy returns to zero
// - step direction 1 increments, 0 decrements
// - move cursor or shift display left or right by shift direction
// - graphics mode 1 graphic, supply on 1 enables converter
package coid_pkg;

    // =====================================================
    // register selection
    localparam logic REG_INSTR = 1'b0;
    localparam logic REG_DATA = 1'b1;

    // =====================================================
    // instruction field positions
    localparam int BIT_STATUS_BUSY = 7;
    localparam int BIT_ENTRY_DIR = 1;
    localparam int BIT_ENTRY_SHIFT = 0;
    localparam int BIT_DISP_ON = 2;
    localparam int BIT_CURSOR = 1;
    localparam int BIT_BLINK = 0;
    localparam int BIT_SHIFT_SEL = 3;
    localparam int BIT_SHIFT_DIR = 2;
    localparam int BIT_GRAPHICS = 3;
    localparam int BIT_SUPPLY = 2;
    localparam int BIT_BUS_WIDTH = 4;
    localparam int BIT_LINES = 3;
    localparam int BIT_FONT_H = 2;
    localparam logic [1:0] SHIFT_SUB_MOVE = 2'h0;
    localparam logic [1:0] SHIFT_SUB_MODE = 2'h3;

    // =====================================================
    // reset values
    localparam logic RST_STEP_DIR = 1'b1;
    localparam logic RST_ENTRY_SHIFT = 1'b0;
    localparam logic RST_DISP_ON = 1'b0;
    localparam logic RST_CURSOR = 1'b0;
    localparam logic RST_BLINK = 1'b0;
    localparam logic RST_GRAPHICS = 1'b0;
    localparam logic RST_SUPPLY = 1'b0;
    localparam logic RST_BUS_WIDTH = 1'b1;
    localparam logic RST_LINES = 1'b0;
    localparam logic RST_FONT_H = 1'b0;
    localparam logic [1:0] RST_FONT_TABLE = 2'h0;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic [7:0] BLANK_CODE = 8'h20;

    // =====================================================
    // memory sizes
    localparam int DISP_AW = 7;
    localparam int GLYPH_AW = 6;
    localparam int DISP_WORDS = 128;

    // =====================================================
    // timing
    localparam int CLK_KHZ = 25000;
    localparam int CLEAR_TIME_US = 6200;
    localparam int CLEAR_CYC = (CLEAR_TIME_US * CLK_KHZ) / 1000;
    localparam int EXEC_CYC = 2;
    localparam int CNT_W = 18;

    // =====================================================
    // types
    typedef enum logic [3:0] {
        OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISPLAY,
        OP_SHIFT, OP_MODE, OP_FUNC, OP_GLYPH, OP_DISP_ADDR
    } coid_op_e;

    typedef enum logic [1:0] {
        ST_IDLE, ST_EXEC, ST_CLEAR
    } coid_state_e;

endpackage : coid_pkg

// file: core/coid_ram.sv
module coid_ram #(
    parameter int AW = 7
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);

    // =====================================================
    // storage
    logic [7:0] mem_ff [0:(1<<AW)-1];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_ff[addr_in] <= wdata_in;
        end
    end

    assign rdata_out = mem_ff[addr_in];

endmodule : coid_ram

// file: core/coid_decoder.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
module coid_decoder #(
    parameter int CLEAR_CYCLES = coid_pkg::CLEAR_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic REG_SEL_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    output logic BUSY_OUT,
    output logic [6:0] ADDR_COUNTER_OUT,
    output logic GLYPH_SEL_OUT,
    output logic STEP_DIR_OUT,
    output logic ENTRY_SHIFT_OUT,
    output logic DISPLAY_ON_OUT,
    output logic CURSOR_VISIBLE_OUT,
    output logic BLINK_OUT,
    output logic GRAPHICS_MODE_OUT,
    output logic SUPPLY_ON_OUT,
    output logic BUS_WIDTH_OUT,
    output logic LINE_COUNT_OUT,
    output logic FONT_HEIGHT_OUT,
    output logic [1:0] FONT_TABLE_OUT,
    output logic [6:0] DISPLAY_SHIFT_OUT
);

    // =====================================================
    // decode by highest set bit
    function automatic coid_pkg::coid_op_e coid_decode(input logic [7:0] b);
        coid_pkg::coid_op_e op;
        op = coid_pkg::OP_NONE;
        if (b[7]) begin
            op = coid_pkg::OP_DISP_ADDR;
        end else if (b[6]) begin
            op = coid_pkg::OP_GLYPH;
        end else if (b[5]) begin
            op = coid_pkg::OP_FUNC;
        end else if (b[4]) begin
            if (b[1:0] == coid_pkg::SHIFT_SUB_MODE) begin
                op = coid_pkg::OP_MODE;
            end else if (b[1:0] == coid_pkg::SHIFT_SUB_MOVE) begin
                op = coid_pkg::OP_SHIFT;
            end
        end else if (b[3]) begin
            op = coid_pkg::OP_DISPLAY;
        end else if (b[2]) begin
            op = coid_pkg::OP_ENTRY;
        end else if (b[1]) begin
            op = coid_pkg::OP_HOME;
        end else if (b[0]) begin
            op = coid_pkg::OP_CLEAR;
        end
        return op;
    endfunction : coid_decode

    // =====================================================
    // state
    coid_pkg::coid_state_e st_ff;
    coid_pkg::coid_state_e nxt_st;
    logic [coid_pkg::CNT_W-1:0] cnt_ff;
    logic [coid_pkg::CNT_W-1:0] nxt_cnt;
    logic [6:0] addr_cnt_ff;
    logic [6:0] shift_ff;
    logic [7:0] clr_addr_ff;
    logic glyph_sel_ff;
    logic step_pend_ff;
    logic step_dir_ff;
    logic entry_shift_ff;
    logic disp_on_ff;
    logic cursor_ff;
    logic blink_ff;
    logic graphics_ff;
    logic supply_ff;
    logic bus_width_ff;
    logic lines_ff;
    logic font_h_ff;
    logic [1:0] font_table_ff;
    logic [7:0] rdata_ff;

    logic busy;
    logic instr_wr;
    logic data_wr;
    logic data_rd;
    logic stat_rd;
    logic clearing;
    logic exec_done;
    coid_pkg::coid_op_e op;
    logic [6:0] addr_up;
    logic [6:0] addr_dn;
    logic dd_we;
    logic gl_we;
    logic [6:0] dd_addr;
    logic [7:0] dd_wdata;
    logic [7:0] dd_rdata;
    logic [7:0] gl_rdata;

    // =====================================================
    // host access qualification
    assign busy = (st_ff != coid_pkg::ST_IDLE);
    assign op = coid_decode(WDATA_IN);
    assign instr_wr = WR_IN && (REG_SEL_IN == coid_pkg::REG_INSTR) && !busy;
    assign data_wr = WR_IN && (REG_SEL_IN == coid_pkg::REG_DATA) && !busy;
    assign data_rd = RD_IN && (REG_SEL_IN == coid_pkg::REG_DATA) && !busy;
    assign stat_rd = RD_IN && (REG_SEL_IN == coid_pkg::REG_INSTR);
    assign clearing = (st_ff == coid_pkg::ST_CLEAR) &&
                      (clr_addr_ff < 8'(coid_pkg::DISP_WORDS));
    assign exec_done = (st_ff != coid_pkg::ST_IDLE) && (cnt_ff == '0);
    assign addr_up = addr_cnt_ff + 7'h01;
    assign addr_dn = addr_cnt_ff - 7'h01;

    // =====================================================
    // execution sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            coid_pkg::ST_IDLE: begin
                if (instr_wr && (op == coid_pkg::OP_CLEAR)) begin
                    nxt_st = coid_pkg::ST_CLEAR;
                    nxt_cnt = coid_pkg::CNT_W'(CLEAR_CYCLES - 1);
                end else if ((instr_wr && (op != coid_pkg::OP_NONE)) || data_wr || data_rd) begin
                    nxt_st = coid_pkg::ST_EXEC;
                    nxt_cnt = coid_pkg::CNT_W'(coid_pkg::EXEC_CYC - 1);
                end
            end
            coid_pkg::ST_EXEC, coid_pkg::ST_CLEAR: begin
                if (cnt_ff == '0) begin
                    nxt_st = coid_pkg::ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_st = coid_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_ff <= coid_pkg::ST_IDLE;
            cnt_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // =====================================================
    // clear sweep over display ram
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            clr_addr_ff <= 8'h00;
        end else if (instr_wr && (op == coid_pkg::OP_CLEAR)) begin
            clr_addr_ff <= 8'h00;
        end else if (clearing) begin
            clr_addr_ff <= clr_addr_ff + 8'h01;
        end
    end

    // =====================================================
    // address counter
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            addr_cnt_ff <= coid_pkg::RST_ADDR;
        end else if (instr_wr) begin
            case (op)
                coid_pkg::OP_CLEAR, coid_pkg::OP_HOME: begin
                    addr_cnt_ff <= coid_pkg::RST_ADDR;
                end
                coid_pkg::OP_DISP_ADDR: begin
                    addr_cnt_ff <= WDATA_IN[6:0];
                end
                coid_pkg::OP_GLYPH: begin
                    addr_cnt_ff <= {1'b0, WDATA_IN[5:0]};
                end
                coid_pkg::OP_SHIFT: begin
                    if (!WDATA_IN[coid_pkg::BIT_SHIFT_SEL]) begin
                        addr_cnt_ff <= WDATA_IN[coid_pkg::BIT_SHIFT_DIR] ? addr_up : addr_dn;
                    end
                end
                default: begin
                    addr_cnt_ff <= addr_cnt_ff;
                end
            endcase
        end else if (exec_done && step_pend_ff) begin
            addr_cnt_ff <= step_dir_ff ? addr_up : addr_dn;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            step_pend_ff <= 1'b0;
        end else if (data_wr || data_rd) begin
            step_pend_ff <= 1'b1;
        end else if (exec_done) begin
            step_pend_ff <= 1'b0;
        end
    end

    // =====================================================
    // ram target selection
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            glyph_sel_ff <= 1'b0;
        end else if (instr_wr && (op == coid_pkg::OP_GLYPH)) begin
            glyph_sel_ff <= 1'b1;
        end else if (instr_wr && ((op == coid_pkg::OP_DISP_ADDR) || (op == coid_pkg::OP_CLEAR) ||
                                  (op == coid_pkg::OP_HOME))) begin
            glyph_sel_ff <= 1'b0;
        end
    end

    // =====================================================
    // display shift offset
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            shift_ff <= 7'h00;
        end else if (instr_wr && ((op == coid_pkg::OP_CLEAR) || (op == coid_pkg::OP_HOME))) begin
            shift_ff <= 7'h00;
        end else if (instr_wr && (op == coid_pkg::OP_SHIFT) &&
                     WDATA_IN[coid_pkg::BIT_SHIFT_SEL]) begin
            shift_ff <= WDATA_IN[coid_pkg::BIT_SHIFT_DIR] ? shift_ff - 7'h01 :
                                                           shift_ff + 7'h01;
        end else if (data_wr && entry_shift_ff && !glyph_sel_ff) begin
            shift_ff <= step_dir_ff ? shift_ff + 7'h01 : shift_ff - 7'h01;
        end
    end

    // =====================================================
    // entry mode bits
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            step_dir_ff <= coid_pkg::RST_STEP_DIR;
            entry_shift_ff <= coid_pkg::RST_ENTRY_SHIFT;
        end else if (instr_wr && (op == coid_pkg::OP_ENTRY)) begin
            step_dir_ff <= WDATA_IN[coid_pkg::BIT_ENTRY_DIR];
            entry_shift_ff <= WDATA_IN[coid_pkg::BIT_ENTRY_SHIFT];
        end else if (instr_wr && (op == coid_pkg::OP_CLEAR)) begin
            step_dir_ff <= 1'b1;
        end
    end

    // =====================================================
    // display control bits
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            disp_on_ff <= coid_pkg::RST_DISP_ON;
            cursor_ff <= coid_pkg::RST_CURSOR;
            blink_ff <= coid_pkg::RST_BLINK;
        end else if (instr_wr && (op == coid_pkg::OP_DISPLAY)) begin
            disp_on_ff <= WDATA_IN[coid_pkg::BIT_DISP_ON];
            cursor_ff <= WDATA_IN[coid_pkg::BIT_CURSOR];
            blink_ff <= WDATA_IN[coid_pkg::BIT_BLINK];
        end
    end

    // =====================================================
    // graphics and supply bits
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            graphics_ff <= coid_pkg::RST_GRAPHICS;
            supply_ff <= coid_pkg::RST_SUPPLY;
        end else if (instr_wr && (op == coid_pkg::OP_MODE)) begin
            graphics_ff <= WDATA_IN[coid_pkg::BIT_GRAPHICS];
            supply_ff <= WDATA_IN[coid_pkg::BIT_SUPPLY];
        end
    end

    // =====================================================
    // function set bits
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bus_width_ff <= coid_pkg::RST_BUS_WIDTH;
            lines_ff <= coid_pkg::RST_LINES;
            font_h_ff <= coid_pkg::RST_FONT_H;
            font_table_ff <= coid_pkg::RST_FONT_TABLE;
        end else if (instr_wr && (op == coid_pkg::OP_FUNC)) begin
            bus_width_ff <= WDATA_IN[coid_pkg::BIT_BUS_WIDTH];
            lines_ff <= WDATA_IN[coid_pkg::BIT_LINES];
            font_h_ff <= WDATA_IN[coid_pkg::BIT_FONT_H];
            font_table_ff <= WDATA_IN[1:0];
        end
    end

    // =====================================================
    // ram ports
    assign dd_we = clearing || (data_wr && !glyph_sel_ff);
    assign gl_we = data_wr && glyph_sel_ff;
    assign dd_addr = clearing ? clr_addr_ff[6:0] : addr_cnt_ff;
    assign dd_wdata = clearing ? coid_pkg::BLANK_CODE : WDATA_IN;

    coid_ram #(
        .AW(coid_pkg::DISP_AW)
    ) u_disp_ram (
        .clk_in(SYS_CLK_IN),
        .we_in(dd_we),
        .addr_in(dd_addr),
        .wdata_in(dd_wdata),
        .rdata_out(dd_rdata)
    );

    coid_ram #(
        .AW(coid_pkg::GLYPH_AW)
    ) u_glyph (
        .clk_in(SYS_CLK_IN),
        .we_in(gl_we),
        .addr_in(addr_cnt_ff[coid_pkg::GLYPH_AW-1:0]),
        .wdata_in(WDATA_IN),
        .rdata_out(gl_rdata)
    );

    // =====================================================
    // read data, one cycle after the strobe
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rdata_ff <= 8'h00;
        end else if (stat_rd) begin
            rdata_ff <= {busy, addr_cnt_ff};
        end else if (data_rd) begin
            rdata_ff <= glyph_sel_ff ? gl_rdata : dd_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // =====================================================
    // outputs
    assign RDATA_OUT = rdata_ff;
    assign BUSY_OUT = busy;
    assign ADDR_COUNTER_OUT = addr_cnt_ff;
    assign GLYPH_SEL_OUT = glyph_sel_ff;
    assign STEP_DIR_OUT = step_dir_ff;
    assign ENTRY_SHIFT_OUT = entry_shift_ff;
    assign DISPLAY_ON_OUT = disp_on_ff;
    assign CURSOR_VISIBLE_OUT = cursor_ff;
    assign BLINK_OUT = blink_ff;
    assign GRAPHICS_MODE_OUT = graphics_ff;
    assign SUPPLY_ON_OUT = supply_ff;
    assign BUS_WIDTH_OUT = bus_width_ff;
    assign LINE_COUNT_OUT = lines_ff;
    assign FONT_HEIGHT_OUT = font_h_ff;
    assign FONT_TABLE_OUT = font_table_ff;
    assign DISPLAY_SHIFT_OUT = shift_ff;

endmodule : coid_decoder

// file: verification/coid_decoder_properties.sv
module coid_decoder_properties #(
    parameter int CLEAR_CYCLES = coid_pkg::CLEAR_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic REG_SEL_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic BUSY_OUT,
    input wire logic [6:0] ADDR_COUNTER_OUT,
    input wire logic GLYPH_SEL_OUT,
    input wire logic STEP_DIR_OUT,
    input wire logic DISPLAY_ON_OUT,
    input wire logic [1:0] FONT_TABLE_OUT,
    input wire logic [6:0] DISPLAY_SHIFT_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    // ========
    // helpers
    wire logic ins_ok = WR_IN && !BUSY_OUT && !REG_SEL_IN;
    wire logic dat_ok = WR_IN && !BUSY_OUT && REG_SEL_IN;
    wire logic [6:0] wlow = WDATA_IN[6:0];
    wire logic [5:0] glow = WDATA_IN[5:0];
    logic [17:0] busy_run_ff;
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            busy_run_ff <= 18'h0_0000;
        end else begin
            busy_run_ff <= BUSY_OUT ? busy_run_ff + 18'h0_0001 : 18'h0_0000;
        end
    end
    // ========
    // assertions
    a_exec_busy_len: assert property (dat_ok |=> BUSY_OUT [*2] ##1 !BUSY_OUT)
        else $error("busy length after data write wrong");
    a_busy_refuses: assert property (WR_IN && BUSY_OUT |=> $stable(DISPLAY_ON_OUT)
        && $stable(FONT_TABLE_OUT) && $stable(GLYPH_SEL_OUT))
        else $error("write taken while busy");
    a_status_word: assert property (RD_IN && !REG_SEL_IN
        |=> RDATA_OUT == {$past(BUSY_OUT), $past(ADDR_COUNTER_OUT)})
        else $error("status word wrong");
    a_read_idle: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data without read");
    a_clear_state: assert property (ins_ok && WDATA_IN == 8'h01 |=> ADDR_COUNTER_OUT == 7'h00
        && DISPLAY_SHIFT_OUT == 7'h00 && STEP_DIR_OUT && !GLYPH_SEL_OUT)
        else $error("clear state wrong");
    a_clear_bound: assert property (BUSY_OUT |-> busy_run_ff < CLEAR_CYCLES)
        else $error("busy too long");
    a_disp_addr_load: assert property (ins_ok && WDATA_IN[7]
        |=> ADDR_COUNTER_OUT == $past(wlow) && !GLYPH_SEL_OUT)
        else $error("display address load wrong");
    a_glyph_load: assert property (ins_ok && WDATA_IN[7:6] == 2'b01
        |=> GLYPH_SEL_OUT && ADDR_COUNTER_OUT == {1'b0, $past(glow)})
        else $error("glyph address load wrong");
    a_step_write: assert property (dat_ok |=> ##2 ADDR_COUNTER_OUT
        == $past(ADDR_COUNTER_OUT, 3) + (STEP_DIR_OUT ? 7'h01 : 7'h7F))
        else $error("counter step wrong");
    a_cursor_move: assert property (ins_ok && WDATA_IN == 8'h14
        |=> ADDR_COUNTER_OUT == $past(ADDR_COUNTER_OUT) + 7'h01)
        else $error("cursor move wrong");
    c_clear: cover property (ins_ok && WDATA_IN == 8'h01);
    c_data_read: cover property (RD_IN && REG_SEL_IN && !BUSY_OUT);
    c_refused: cover property (WR_IN && BUSY_OUT);
endmodule : coid_decoder_properties

bind coid_decoder coid_decoder_properties #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_props (
    .SYS_CLK_IN, .RST_B_IN, .REG_SEL_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .BUSY_OUT,
    .ADDR_COUNTER_OUT, .GLYPH_SEL_OUT, .STEP_DIR_OUT, .DISPLAY_ON_OUT, .FONT_TABLE_OUT,
    .DISPLAY_SHIFT_OUT
);

// file: verification/coid_host.sv
module coid_host (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic reg_sel_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic chk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int hang_count = 0;
    initial begin
        reg_sel_out = 1'b0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        chk_out = 1'b0;
    end
    task automatic wr(input logic sel, input logic [7:0] d);
        reg_sel_out <= sel;
        wdata_out <= d;
        wr_out <= 1'b1;
        rd_out <= 1'b0;
        chk_out <= 1'b0;
        @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic sel, input logic chk);
        reg_sel_out <= sel;
        wdata_out <= ~wdata_out;
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        chk_out <= chk;
        @(posedge clk_in);
    endtask : rd
    task automatic rel;
        wdata_out <= ~wdata_out;
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        chk_out <= 1'b0;
        @(posedge clk_in);
    endtask : rel
    // poll status until not busy
    task automatic wait_idle;
        logic b;
        int n;
        b = 1'b1;
        n = 0;
        rd(1'b0, 1'b0);
        while (b && n < 400) begin
            rd(1'b0, 1'b0);
            b = rdata_in[7];
            n++;
        end
        if (b) begin
            hang_count++;
        end
        rel();
    endtask : wait_idle
endmodule : coid_host

// file: verification/coid_decoder_bench.sv
module coid_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CLR = 200;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_sel, wr, rd, chk, busy, gsel, sdir, eshift, don, cur, blk, gfx, sup, bw, lc, fh;
    logic [7:0] wdata, rdata, r;
    logic [6:0] addr_cnt, shift, a;
    logic [1:0] ftab;
    logic [7:0] mem [128];
    logic [15:0] q [$];
    logic pend = 1'b0;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 81;
    always #20 sys_clk = ~sys_clk;
    coid_decoder #(.CLEAR_CYCLES(CLR)) dut (
        .SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b), .REG_SEL_IN(reg_sel), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BUSY_OUT(busy), .ADDR_COUNTER_OUT(addr_cnt),
        .GLYPH_SEL_OUT(gsel), .STEP_DIR_OUT(sdir), .ENTRY_SHIFT_OUT(eshift),
        .DISPLAY_ON_OUT(don), .CURSOR_VISIBLE_OUT(cur), .BLINK_OUT(blk),
        .GRAPHICS_MODE_OUT(gfx), .SUPPLY_ON_OUT(sup), .BUS_WIDTH_OUT(bw),
        .LINE_COUNT_OUT(lc), .FONT_HEIGHT_OUT(fh), .FONT_TABLE_OUT(ftab),
        .DISPLAY_SHIFT_OUT(shift)
    );
    coid_host host (
        .clk_in(sys_clk), .rdata_in(rdata), .reg_sel_out(reg_sel), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .chk_out(chk)
    );
    // ========
    // tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        fail_count += host.hang_count;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic ins(input logic [7:0] d);
        host.wr(1'b0, d);
        host.wait_idle();
    endtask : ins
    task automatic dat(input logic [7:0] d);
        host.wr(1'b1, d);
        host.wait_idle();
    endtask : dat
    task automatic rdx(input logic [7:0] d);
        q.push_back({8'h00, d});
        host.rd(1'b1, 1'b1);
        host.wait_idle();
    endtask : rdx
    task automatic stat(input logic [6:0] exp_addr);
        q.push_back({9'h000, exp_addr});
        host.rd(1'b0, 1'b1);
        host.rel();
    endtask : stat
    // ========
    // read monitor
    always @(posedge sys_clk) begin
        if (pend) begin
            check("read data", {8'h00, rdata}, q.pop_front());
        end
        pend <= rd && chk;
    end
    initial begin
        #400_000;
        fail_count++;
        $display("watchdog expired");
        wrap_up();
    end
    // ========
    // tests
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        check("reset", {sdir, bw, don, ftab}, {coid_pkg::RST_STEP_DIR,
            coid_pkg::RST_BUS_WIDTH, coid_pkg::RST_DISP_ON, coid_pkg::RST_FONT_TABLE});
        stat(coid_pkg::RST_ADDR);
        $display("test reset done");
        for (int j = 0; j < 8; j++) begin
            r = 8'($random(seed));
            ins({3'b001, r[4:2], j[1:0]});
            check("function", {bw, lc, fh, ftab}, {r[4:2], j[1:0]});
            ins({5'b00001, j[2:0]});
            check("display", {don, cur, blk}, j[2:0]);
            ins({6'b000001, r[6], j[0]});
            check("entry", {sdir, eshift}, {r[6], j[0]});
            ins({4'b0001, j[1:0], 2'b11});
            check("mode", {gfx, sup}, j[1:0]);
        end
        ins(8'h06);
        $display("test instructions done");
        ins(8'h8A);
        q.push_back(16'h0000);
        host.wr(1'b0, 8'h08);
        host.wr(1'b0, 8'h0F);
        host.rd(1'b1, 1'b1);
        host.wait_idle();
        mem[7'h0A] = 8'h33;
        host.wr(1'b1, 8'h33);
        host.wr(1'b1, 8'h55);
        host.wait_idle();
        check("refused", {don, cur, blk, addr_cnt}, {3'b000, 7'h0B});
        $display("test busy refusal done");
        a = 7'($random(seed));
        ins({1'b1, a});
        for (int k = 0; k < 6; k++) begin
            mem[a + 7'(k)] = 8'($random(seed));
            dat(mem[a + 7'(k)]);
        end
        stat(a + 7'h06);
        ins({1'b1, a});
        for (int k = 0; k < 6; k++) begin
            rdx(mem[a + 7'(k)]);
        end
        stat(a + 7'h06);
        ins(8'h04);
        ins({1'b1, a});
        mem[a] = 8'hC3;
        dat(8'hC3);
        stat(a - 7'h01);
        ins(8'h06);
        $display("test data transfer done");
        ins({2'b01, a[5:0]});
        check("glyph", {gsel, addr_cnt}, {2'b10, a[5:0]});
        dat(8'h1F);
        ins({2'b01, a[5:0]});
        rdx(8'h1F);
        ins(8'h80);
        check("display sel", {gsel, addr_cnt}, 16'h0000);
        $display("test glyph done");
        ins(8'h94);
        for (int k = 0; k < 4; k++) begin
            ins(8'h10 | (8'(k) << 2));
            check("move", {addr_cnt, shift}, {(k == 0) ? 7'h13 : 7'h14,
                (k == 2) ? 7'h01 : 7'h00});
        end
        ins(8'h07);
        mem[7'h14] = 8'h41;
        dat(8'h41);
        check("entry shift", {shift, addr_cnt}, {7'h01, 7'h15});
        host.wr(1'b0, 8'h11);
        host.rel();
        check("ignored", {busy, addr_cnt, shift}, {1'b0, 7'h15, 7'h01});
        ins(8'h06);
        $display("test shift done");
        host.wr(1'b0, 8'h02);
        host.wait_idle();
        check("home", {addr_cnt, shift, gsel}, 16'h0000);
        ins(8'h8A);
        rdx(mem[7'h0A]);
        ins(8'h04);
        ins(8'h01);
        check("clear", {addr_cnt, shift, sdir}, 16'h0001);
        ins({1'b1, a});
        rdx(coid_pkg::BLANK_CODE);
        $display("test home and clear done");
        wrap_up();
    end
endmodule : coid_decoder_bench
